//--- src/pcl_pkg.sv
package pcl_pkg;
   // cluster geometry
   localparam int          PCL_CELLS     = 16;          // cells on one carry chain
   localparam int          PCL_ADDR_W    = 8;           // byte address width
   // register byte offsets
   localparam logic [7:0]  PCL_CFG_OFS   = 8'h00;       // cell configs, one word per cell
   localparam logic [7:0]  PCL_CTRL_OFS  = 8'h40;       // cluster control
   localparam logic [7:0]  PCL_STAT_OFS  = 8'h44;       // cluster status
   // cell config field positions
   localparam int          PCL_LUT_LSB   = 0;           // lookup mask
   localparam int          PCL_LUT_W     = 16;
   localparam int          PCL_MODE_BIT  = 16;          // 1 = arithmetic
   localparam int          PCL_FF_LSB    = 17;          // storage type
   localparam int          PCL_OSEL_LSB  = 19;          // output selects a, b, local
   localparam int          PCL_CIN_BIT   = 22;          // carry-in as fourth lookup input
   localparam int          PCL_FB_BIT    = 23;          // register feedback
   localparam int          PCL_PACK_BIT  = 24;          // packed register
   localparam int          PCL_CHAIN_BIT = 25;          // register takes chain input
   // control field positions
   localparam int          PCL_CLKS_LSB  = 0;           // clock source
   localparam int          PCL_CLRS_LSB  = 2;           // clear source
   localparam int          PCL_ENAS_BIT  = 4;           // enable source, 1 = internal
   localparam int          PCL_SCLR_BIT  = 5;           // synchronous clear
   localparam int          PCL_SLOAD_BIT = 6;           // synchronous load
   // reset values
   localparam logic [31:0] PCL_CFG_RST   = 32'h00000000;
   localparam logic [31:0] PCL_CTRL_RST  = 32'h00000000;
   // bus responses
   localparam logic [1:0]  PCL_OKAY      = 2'h0;
   localparam logic [1:0]  PCL_SLVERR    = 2'h2;

   typedef enum logic [1:0] {PCL_FF_D, PCL_FF_T, PCL_FF_JK, PCL_FF_SR} pcl_ff_t;
   typedef enum logic [1:0] {PCL_SRC_GLOBAL, PCL_SRC_PIN, PCL_SRC_INTERNAL} pcl_src_t;

   // cell state
   typedef struct packed {
      logic q;
   } pcl_cell_st_t;

   // cluster state
   typedef struct packed {
      logic [PCL_CELLS-1:0][31:0] cfg;
      logic [31:0]                ctrl;
      logic                       aw_got;
      logic [PCL_ADDR_W-1:0]      awaddr;
      logic                       w_got;
      logic [31:0]                wdata;
      logic [3:0]                 wstrb;
      logic                       bvalid;
      logic [1:0]                 bresp;
      logic                       rvalid;
      logic [31:0]                rdata;
      logic [1:0]                 rresp;
      logic [3:0]                 sync1;
      logic [3:0]                 sync2;
      logic                       pin_clk_prev;
      logic                       int_clk_prev;
   } pcl_st_t;
endpackage : pcl_pkg

//--- src/pcl_cell.sv
`timescale 1ns/100ps
`default_nettype none
module pcl_cell
   import pcl_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [31:0] cfg,
   input  wire logic [3:0]  data_in,
   input  wire logic        carry_in,
   input  wire logic        chain_in,
   input  wire logic        tick,
   input  wire logic        clr,
   input  wire logic        sclr,
   input  wire logic        sload,
   output logic             lut_out,
   output logic             reg_out,
   output logic             route_a,
   output logic             route_b,
   output logic             local_out,
   output logic             carry_out,
   output logic             chain_out
);
   pcl_cell_st_t st_q;      // registered state
   pcl_cell_st_t st_d;      // next state
   logic [3:0]   lut_idx;   // lookup address
   logic         din;       // register data
   logic         ff_next;   // storage function result
   logic         arith;     // arithmetic mode
   logic         pack;      // packed register
   logic [2:0]   osel;      // output selects
   pcl_ff_t      ff;        // storage type

   assign arith = cfg[PCL_MODE_BIT];
   assign pack  = cfg[PCL_PACK_BIT];
   assign osel  = cfg[PCL_OSEL_LSB +: 3];
   assign ff    = pcl_ff_t'(cfg[PCL_FF_LSB +: 2]);

   // clear masks the register at once
   assign reg_out = clr ? 1'b0 : st_q.q;

   // lookup inputs, feedback and carry selection
   always_comb begin
      lut_idx[0] = data_in[0];
      lut_idx[1] = cfg[PCL_FB_BIT] ? reg_out : data_in[1];
      lut_idx[2] = data_in[2];
      lut_idx[3] = cfg[PCL_CIN_BIT] ? carry_in : data_in[3];
   end

   // lookup or adder result
   always_comb begin
      if (arith) begin
         lut_out   = lut_idx[0] ^ lut_idx[1] ^ carry_in;
         carry_out = (lut_idx[0] & lut_idx[1]) | (carry_in & (lut_idx[0] ^ lut_idx[1]));
      end else begin
         lut_out   = cfg[PCL_LUT_LSB + int'(lut_idx)];
         carry_out = 1'b0;
      end
   end

   // register data: chain, direct input when packed, or lookup
   assign din = cfg[PCL_CHAIN_BIT] ? chain_in : (pack ? data_in[3] : lut_out);

   // storage function, second control taken from data input 2
   always_comb begin
      case (ff)
         PCL_FF_D:  ff_next = din;
         PCL_FF_T:  ff_next = st_q.q ^ din;
         PCL_FF_JK: ff_next = (din & ~st_q.q) | (~data_in[2] & st_q.q);
         PCL_FF_SR: ff_next = din | (~data_in[2] & st_q.q);
         default:   ff_next = st_q.q;
      endcase
   end

   // register update priorities
   always_comb begin
      st_d = st_q;
      if (clr) begin
         st_d.q = 1'b0;
      end else if (tick) begin
         if (sclr) begin
            st_d.q = 1'b0;
         end else if (sload && !pack) begin
            st_d.q = data_in[3];
         end else begin
            st_d.q = ff_next;
         end
      end
   end

   // state register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   // three independent outputs, lookup or register
   assign route_a   = osel[0] ? reg_out : lut_out;
   assign route_b   = osel[1] ? reg_out : lut_out;
   assign local_out = osel[2] ? reg_out : lut_out;
   assign chain_out = reg_out;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_adder_sum: assert property (arith |-> {carry_out, lut_out}
      == ({1'b0, data_in[0]} + {1'b0, lut_idx[1]} + {1'b0, carry_in}))
      else $error("adder sum wrong");
   a_bypass_out: assert property (!osel[0] && !osel[2] |-> (route_a == lut_out) && (local_out == lut_out))
      else $error("combinational bypass wrong");
   a_toggle_ff: assert property ((ff == PCL_FF_T) && tick && !clr && !sclr && !(sload && !pack) && din ##1 !clr
      |-> reg_out == !$past(st_q.q))
      else $error("toggle register failed");
endmodule : pcl_cell
`default_nettype wire

//--- src/pcl_cluster.sv
// Notes on behaviour
// - four-input lookup realises any function
// - register works as D, T, JK, SR
// - register has data, clock, enable, clear
// - clock, clear from global, pin, internal
// - combinational result bypasses register to outputs
// - three outputs, each lookup or register
// - two routed outputs, one local output
// - packed register cannot use synchronous load
// - register output may feed own lookup
// - registered and unregistered results together
// - register chain cascades cells as shifter
// - six inputs routed per mode
// - register controls come cluster-wide
// - carry-in or fourth input feeds lookup
// - arithmetic mode adds with carry out
// - arithmetic keeps feedback, packing, dual outputs
// - sixteen cells per chain, chain continues
// - synchronous clear, load act on all; load skips packed cells
// - enable low stops clock, registers hold
// - device-wide clear resets all, overrides
`timescale 1ns/100ps
`default_nettype none
module pcl_cluster
   import pcl_pkg::*;
(
   input  wire logic                   aclk,
   input  wire logic                   aresetn,
   // register bus
   input  wire logic [PCL_ADDR_W-1:0]  s_axi_awaddr,
   input  wire logic [2:0]             s_axi_awprot,
   input  wire logic                   s_axi_awvalid,
   output logic                        s_axi_awready,
   input  wire logic [31:0]            s_axi_wdata,
   input  wire logic [3:0]             s_axi_wstrb,
   input  wire logic                   s_axi_wvalid,
   output logic                        s_axi_wready,
   output logic [1:0]                  s_axi_bresp,
   output logic                        s_axi_bvalid,
   input  wire logic                   s_axi_bready,
   input  wire logic [PCL_ADDR_W-1:0]  s_axi_araddr,
   input  wire logic [2:0]             s_axi_arprot,
   input  wire logic                   s_axi_arvalid,
   output logic                        s_axi_arready,
   output logic [31:0]                 s_axi_rdata,
   output logic [1:0]                  s_axi_rresp,
   output logic                        s_axi_rvalid,
   input  wire logic                   s_axi_rready,
   // control sources
   input  wire logic                   global_clk_en,
   input  wire logic                   global_clr,
   input  wire logic                   pin_clk,
   input  wire logic                   pin_clr,
   input  wire logic                   pin_ena,
   input  wire logic                   int_clk,
   input  wire logic                   int_clr,
   input  wire logic                   int_ena,
   input  wire logic                   device_wide_clear_n,
   // cell data and chains
   input  wire logic [PCL_CELLS*4-1:0] data_in,
   input  wire logic                   carry_in,
   input  wire logic                   chain_in,
   output logic [PCL_CELLS-1:0]        route_a,
   output logic [PCL_CELLS-1:0]        route_b,
   output logic [PCL_CELLS-1:0]        local_out,
   output logic                        carry_out,
   output logic                        chain_out
);
   pcl_st_t              st_q;        // registered state
   pcl_st_t              st_d;        // next state
   logic [PCL_CELLS:0]   carry;       // carry chain taps
   logic [PCL_CELLS:0]   chain;       // register chain taps
   logic [PCL_CELLS-1:0] reg_res;     // per-cell register outputs
   logic [PCL_CELLS-1:0] fourth_vec;  // per-cell data input 3
   logic [PCL_CELLS-1:0] pack_vec;    // per-cell packed flags
   logic                 tick;        // enabled clock edge
   logic                 clk_edge;    // selected clock edge
   logic                 ena;         // selected enable
   logic                 clr_sel;     // selected clear
   logic                 clr_all;     // clear after device-wide override
   logic                 sclr;        // cluster synchronous clear
   logic                 sload;       // cluster synchronous load
   logic                 dev_clr_n_s; // synchronised device clear
   logic                 pin_clk_s;   // synchronised pin clock
   logic                 pin_clr_s;   // synchronised pin clear
   logic                 pin_ena_s;   // synchronised pin enable

   // bus handshakes
   assign s_axi_awready = !st_q.aw_got && !st_q.bvalid;
   assign s_axi_wready  = !st_q.w_got && !st_q.bvalid;
   assign s_axi_arready = !st_q.rvalid;
   assign s_axi_bvalid  = st_q.bvalid;
   assign s_axi_bresp   = st_q.bresp;
   assign s_axi_rvalid  = st_q.rvalid;
   assign s_axi_rdata   = st_q.rdata;
   assign s_axi_rresp   = st_q.rresp;

   // second synchroniser stage outputs
   assign pin_clk_s   = st_q.sync2[0];
   assign pin_clr_s   = st_q.sync2[1];
   assign pin_ena_s   = st_q.sync2[2];
   assign dev_clr_n_s = st_q.sync2[3];

   // cluster-wide controls from software
   assign sclr  = st_q.ctrl[PCL_SCLR_BIT];
   assign sload = st_q.ctrl[PCL_SLOAD_BIT];

   // clock source select; pin and internal clocks become rising-edge pulses
   always_comb begin
      case (pcl_src_t'(st_q.ctrl[PCL_CLKS_LSB +: 2]))
         PCL_SRC_GLOBAL:   clk_edge = global_clk_en;
         PCL_SRC_PIN:      clk_edge = pin_clk_s && !st_q.pin_clk_prev;
         PCL_SRC_INTERNAL: clk_edge = int_clk && !st_q.int_clk_prev;
         default:          clk_edge = 1'b0;
      endcase
   end

   // clear source select
   always_comb begin
      case (pcl_src_t'(st_q.ctrl[PCL_CLRS_LSB +: 2]))
         PCL_SRC_GLOBAL:   clr_sel = global_clr;
         PCL_SRC_PIN:      clr_sel = pin_clr_s;
         PCL_SRC_INTERNAL: clr_sel = int_clr;
         default:          clr_sel = 1'b0;
      endcase
   end

   // enable only from pin or internal logic
   assign ena     = st_q.ctrl[PCL_ENAS_BIT] ? int_ena : pin_ena_s;
   // disabled enable turns the cluster clock off
   assign tick    = clk_edge && ena;
   // device-wide clear overrides everything
   assign clr_all = !dev_clr_n_s || clr_sel;

   // byte-lane merge for register writes
   function automatic logic [31:0] pcl_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
      logic [31:0] res;
      res = old_v;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      return res;
   endfunction : pcl_merge

   // read decode
   function automatic logic [33:0] pcl_read(input pcl_st_t s,
                                            input logic [PCL_ADDR_W-1:0] a,
                                            input logic [PCL_CELLS-1:0] q,
                                            input logic co);
      logic [33:0] res;
      res = {PCL_OKAY, 32'h00000000};
      if (a[7:6] == PCL_CFG_OFS[7:6]) begin
         res[31:0] = s.cfg[a[5:2]];
      end else if ({a[7:2], 2'b00} == PCL_CTRL_OFS) begin
         res[31:0] = s.ctrl;
      end else if ({a[7:2], 2'b00} == PCL_STAT_OFS) begin
         res[31:0] = {15'h0, co, q};
      end else begin
         res[33:32] = PCL_SLVERR;
      end
      return res;
   endfunction : pcl_read

   // next-state logic: synchronisers, bus slave
   always_comb begin
      st_d = st_q;
      // pins pass two flip-flops
      st_d.sync1        = {device_wide_clear_n, pin_ena, pin_clr, pin_clk};
      st_d.sync2        = st_q.sync1;
      st_d.pin_clk_prev = pin_clk_s;
      st_d.int_clk_prev = int_clk;
      // write address capture
      if (s_axi_awvalid && s_axi_awready) begin
         st_d.aw_got = 1'b1;
         st_d.awaddr = s_axi_awaddr;
      end
      // write data capture
      if (s_axi_wvalid && s_axi_wready) begin
         st_d.w_got = 1'b1;
         st_d.wdata = s_axi_wdata;
         st_d.wstrb = s_axi_wstrb;
      end
      // write response retired
      if (st_q.bvalid && s_axi_bready) begin
         st_d.bvalid = 1'b0;
      end
      // write performed once both halves are in
      if (st_q.aw_got && st_q.w_got && !st_q.bvalid) begin
         st_d.aw_got = 1'b0;
         st_d.w_got  = 1'b0;
         st_d.bvalid = 1'b1;
         st_d.bresp  = PCL_OKAY;
         if (st_q.awaddr[7:6] == PCL_CFG_OFS[7:6]) begin
            // cell configuration word
            st_d.cfg[st_q.awaddr[5:2]] = pcl_merge(st_q.cfg[st_q.awaddr[5:2]], st_q.wdata, st_q.wstrb);
         end else if ({st_q.awaddr[7:2], 2'b00} == PCL_CTRL_OFS) begin
            // cluster control word
            st_d.ctrl = pcl_merge(st_q.ctrl, st_q.wdata, st_q.wstrb);
         end else if ({st_q.awaddr[7:2], 2'b00} != PCL_STAT_OFS) begin
            // unmapped
            st_d.bresp = PCL_SLVERR;
         end
      end
      // read response retired
      if (st_q.rvalid && s_axi_rready) begin
         st_d.rvalid = 1'b0;
      end
      // read taken
      if (s_axi_arvalid && s_axi_arready) begin
         st_d.rvalid                  = 1'b1;
         {st_d.rresp, st_d.rdata}     = pcl_read(st_q, s_axi_araddr, reg_res, carry_out);
      end
   end

   // state register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q      <= '0;
         st_q.cfg  <= {PCL_CELLS{PCL_CFG_RST}};
         st_q.ctrl <= PCL_CTRL_RST;
      end else begin
         st_q <= st_d;
      end
   end

   // chain ends: carry continues to the next cluster in the column
   assign carry[0]  = carry_in;
   assign chain[0]  = chain_in;
   assign carry_out = carry[PCL_CELLS];
   assign chain_out = chain[PCL_CELLS];

   // sixteen cells sharing the cluster-wide controls
   for (genvar i = 0; i < PCL_CELLS; i++) begin : g_cell
      assign fourth_vec[i] = data_in[i*4+3];
      assign pack_vec[i]   = st_q.cfg[i][PCL_PACK_BIT];
      pcl_cell u_cell (
         .aclk      (aclk),
         .aresetn   (aresetn),
         .cfg       (st_q.cfg[i]),
         .data_in   (data_in[i*4 +: 4]),
         .carry_in  (carry[i]),
         .chain_in  (chain[i]),
         .tick      (tick),
         .clr       (clr_all),
         .sclr      (sclr),
         .sload     (sload),
         .lut_out   (),
         .reg_out   (reg_res[i]),
         .route_a   (route_a[i]),
         .route_b   (route_b[i]),
         .local_out (local_out[i]),
         .carry_out (carry[i+1]),
         .chain_out (chain[i+1])
      );
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // quiet edge: no clear now or next cycle
   sequence s_no_clr_tick;
      tick && !clr_all ##1 !clr_all;
   endsequence

   // idle edge: no clock, no clear
   sequence s_idle;
      !tick && !clr_all ##1 !clr_all;
   endsequence

   a_clear_zero: assert property (clr_all |-> reg_res == '0)
      else $error("clear did not zero registers");
   a_dev_clear_all: assert property (!dev_clr_n_s ##1 !clr_all |-> reg_res == '0)
      else $error("device clear lost");
   a_hold_state: assert property (s_idle |-> reg_res == $past(reg_res))
      else $error("registers moved without clock");
   a_sclr_wins: assert property (sclr && sload ##0 s_no_clr_tick |-> reg_res == '0)
      else $error("sync clear did not win");
   a_sload_pack: assert property (!sclr && sload ##0 s_no_clr_tick
      |-> (reg_res & ~$past(pack_vec)) == ($past(fourth_vec) & ~$past(pack_vec)))
      else $error("sync load wrong");
   a_chain_shift: assert property (!sclr && !sload && st_q.cfg[1][PCL_CHAIN_BIT]
      && (st_q.cfg[1][PCL_FF_LSB +: 2] == 2'h0) ##0 s_no_clr_tick |-> reg_res[1] == $past(reg_res[0]))
      else $error("register chain did not shift");
   a_pin_enable: assert property (!st_q.ctrl[PCL_ENAS_BIT] && !pin_ena_s |-> !tick)
      else $error("tick with enable low");
   a_write_resp: assert property (st_q.aw_got && st_q.w_got && !st_q.bvalid |=> s_axi_bvalid [*1])
      else $error("write response missing");
endmodule : pcl_cluster
`default_nettype wire

//--- verification/pcl_neighbour.sv
`timescale 1ns/100ps
`default_nettype none
// tail of the previous cluster: its last chain register and its carry stage
module pcl_neighbour (
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic carry_set,
   input  wire logic chain_set,
   output logic      carry_out,
   output logic      chain_out
);
   // both outputs are registered; a real neighbour cell registers only its chain output, its carry is combinational
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         carry_out <= 1'b0;
         chain_out <= 1'b0;
      end else begin
         carry_out <= carry_set;
         chain_out <= chain_set;
      end
   end
endmodule : pcl_neighbour
`default_nettype wire

//--- verification/programmable_logic_cell_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module programmable_logic_cell_tb_top
   import pcl_pkg::*;
;
   // bus and control drivers
   logic        aclk = 1'b0, aresetn = 1'b0;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h00000000;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic        global_clk_en = 1'b0, global_clr = 1'b0, int_ena = 1'b1, device_wide_clear_n = 1'b1;
   logic        pin_clk = 1'b0, pin_clr = 1'b0, pin_ena = 1'b0, int_clk = 1'b0, int_clr = 1'b0;
   logic        carry_set = 1'b0, chain_set = 1'b0;
   logic [63:0] data_in = 64'h0;
   // design outputs
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic        carry_in, chain_in, carry_out, chain_out;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic [15:0] route_a, route_b, local_out;
   int          miscompares = 0, checks_done = 0;
   // rows: cfg, data nibble, {carry, chain, lookup out, register out}
   logic [39:0] rows [12] = '{40'h00308000F3, 40'h0030800070, 40'h0030699613, 40'h003100003B,
      40'h0031000018, 40'h007080007B, 40'h0130000081, 40'h0230000005, 40'h0032FFFF02,
      40'h0034FFFF43, 40'h00B0333300, 40'h0036000040};

   always #10 aclk = ~aclk;

   pcl_cluster DUT (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .global_clk_en, .global_clr,
      .pin_clk, .pin_clr, .pin_ena, .int_clk, .int_clr, .int_ena, .device_wide_clear_n,
      .data_in, .carry_in, .chain_in, .route_a, .route_b, .local_out, .carry_out, .chain_out);

   // previous cluster feeding carry and chain
   pcl_neighbour u_prev (.aclk, .aresetn, .carry_set, .chain_set, .carry_out(carry_in),
      .chain_out(chain_in));

   // value compare
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // verdict and end of run
   task automatic complete_run;
      if (miscompares == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : complete_run

   // one bus transfer; read data compared against d, response against er
   task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int   n;
      logic ha, hw, hr, hd;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_araddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= wr;
      s_axi_wvalid <= wr;
      s_axi_bready <= wr;
      s_axi_arvalid <= !wr;
      s_axi_rready <= !wr;
      for (n = 0; n < 50; n++) begin
         // handshakes judged mid-cycle, acted on at the next edge
         @(negedge aclk);
         ha = s_axi_awvalid & s_axi_awready;
         hw = s_axi_wvalid & s_axi_wready;
         hr = s_axi_arvalid & s_axi_arready;
         hd = wr ? s_axi_bvalid : s_axi_rvalid;
         if (hd) chk(wr ? s_axi_bresp : s_axi_rresp, er);
         if (hd && !wr) chk(s_axi_rdata, d);
         @(posedge aclk);
         if (ha) s_axi_awvalid <= 1'b0;
         if (hw) s_axi_wvalid <= 1'b0;
         if (hr) s_axi_arvalid <= 1'b0;
         if (hd) begin
            s_axi_bready <= 1'b0;
            s_axi_rready <= 1'b0;
            break;
         end
      end
      if (n == 50) begin
         miscompares++;
         complete_run();
      end
   endtask : axi

   // one global clock edge with the internal enable at en
   task automatic tick(input logic en);
      @(posedge aclk);
      global_clk_en <= 1'b1;
      int_ena <= en;
      @(posedge aclk);
      global_clk_en <= 1'b0;
      int_ena <= 1'b1;
      @(negedge aclk);
   endtask : tick

   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (3) @(posedge aclk);
      axi(1'b0, PCL_CTRL_OFS, PCL_CTRL_RST, PCL_OKAY);
      axi(1'b0, PCL_CFG_OFS, PCL_CFG_RST, PCL_OKAY);
      axi(1'b0, PCL_STAT_OFS, 32'h00000000, PCL_OKAY);
      axi(1'b0, 8'h48, 32'h00000000, PCL_SLVERR);
      axi(1'b1, PCL_CTRL_OFS, 32'h0000001C, PCL_OKAY);
      // table of cell settings: lookup now, register after one edge
      foreach (rows[i]) begin
         axi(1'b1, PCL_CFG_OFS, rows[i][39:8], PCL_OKAY);
         data_in[3:0] <= rows[i][7:4];
         carry_set <= rows[i][3];
         chain_set <= rows[i][2];
         repeat (3) @(posedge aclk);
         @(negedge aclk);
         chk(route_a[0], rows[i][1]);
         tick(1'b1);
         chk({route_b[0], local_out[0]}, {2{rows[i][0]}});
      end
      // enable low holds the register
      axi(1'b1, PCL_CFG_OFS, 32'h00308000, PCL_OKAY);
      data_in[3:0] <= 4'hF;
      tick(1'b0);
      chk(route_b[0], 1'b0);
      tick(1'b1);
      chk(route_b[0], 1'b1);
      // clear wins over load, then load alone
      data_in[3:0] <= 4'h8;
      axi(1'b1, PCL_CTRL_OFS, 32'h0000007C, PCL_OKAY);
      tick(1'b1);
      chk(route_b[0], 1'b0);
      axi(1'b1, PCL_CTRL_OFS, 32'h0000005C, PCL_OKAY);
      tick(1'b1);
      chk(route_b[0], 1'b1);
      axi(1'b0, PCL_STAT_OFS, 32'h00000001, PCL_OKAY);
      // global clear acts within the cycle
      axi(1'b1, PCL_CTRL_OFS, 32'h00000010, PCL_OKAY);
      global_clr <= 1'b1;
      @(negedge aclk);
      chk(route_b[0], 1'b0);
      @(posedge aclk);
      global_clr <= 1'b0;
      // device-wide clear overrides an enabled edge
      axi(1'b1, PCL_CTRL_OFS, 32'h0000001C, PCL_OKAY);
      data_in[3:0] <= 4'hF;
      tick(1'b1);
      chk(route_b[0], 1'b1);
      device_wide_clear_n <= 1'b0;
      repeat (4) @(posedge aclk);
      tick(1'b1);
      chk({route_b[0], chain_out}, 2'h0);
      device_wide_clear_n <= 1'b1;
      repeat (3) @(posedge aclk);
      @(negedge aclk);
      chk(route_b[0], 1'b0);
      // all cells add and chain: carry ripples through, register chain shifts
      data_in <= {16{4'h1}};
      carry_set <= 1'b1;
      chain_set <= 1'b1;
      for (int c = 0; c < PCL_CELLS; c++) begin
         axi(1'b1, PCL_CFG_OFS + 8'(c * 4), 32'h02010000, PCL_OKAY);
      end
      @(negedge aclk);
      chk(carry_out, 1'b1);
      tick(1'b1);
      axi(1'b0, PCL_STAT_OFS, 32'h00010001, PCL_OKAY);
      carry_set <= 1'b0;
      tick(1'b1);
      chk(carry_out, 1'b0);
      axi(1'b0, PCL_STAT_OFS, 32'h00000003, PCL_OKAY);
      // pin clock with pin enable, then internal clock: one shift each
      axi(1'b1, PCL_CTRL_OFS, 32'h0000000D, PCL_OKAY);
      pin_ena <= 1'b1;
      pin_clk <= 1'b1;
      repeat (6) @(posedge aclk);
      axi(1'b0, PCL_STAT_OFS, 32'h00000007, PCL_OKAY);
      axi(1'b1, PCL_CTRL_OFS, 32'h0000001E, PCL_OKAY);
      int_clk <= 1'b1;
      repeat (2) @(posedge aclk);
      axi(1'b0, PCL_STAT_OFS, 32'h0000000F, PCL_OKAY);
      // reset in mid-run returns control and registers to reset values
      int_clk <= 1'b0;
      pin_clk <= 1'b0;
      aresetn <= 1'b0;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (3) @(posedge aclk);
      axi(1'b0, PCL_CTRL_OFS, PCL_CTRL_RST, PCL_OKAY);
      axi(1'b0, PCL_STAT_OFS, 32'h00000000, PCL_OKAY);
      complete_run();
   end
endmodule : programmable_logic_cell_tb_top
`default_nettype wire
